// ### cpu_exec_core.sv
// Execution core of an 8-bit controller: one decoded instruction at a time against data and program memory.
// Operation
// - True condition runs the next instruction; false condition skips it.
// - Add and subtract with carry update accumulator, carry and half carry.
// - And-immediate-skip skips next when accumulator AND immediate is zero, no write-back.
// - Direct compare runs next only if memory byte equals immediate.
// - Accumulator equal, not-equal, greater tests run next only when relation holds.
// - Pointer nibble test runs next only if low four pointer bits differ.
// - Decrement register-page byte by one, skip next when result is zero.
// - Bit set and clear write one bit, other bits unchanged.
// - Post-adjust forms use current pointer, then step it by one.
// - Table read loads accumulator from program byte at high counter and accumulator.
// - Rotate right through carry: carry into bit 7, bit 0 into carry.
// - Rotate left through carry, old bit 0 also into half carry.
// - Push writes then decrements stack pointer; pop increments then reads.
// - Vector dispatch loads counter high then low from adjacent program bytes.
// - Long jump loads the full 15-bit program counter.
// - Absolute jump loads low 12 counter bits, upper bits kept.
// - Relative jump adds signed displacement -64 to +63 to the counter.
// - Calls stack low byte at pointer, high byte below, drop pointer by two.
// - Boot call stacks return, loads low byte, clears high, fetches boot memory.
// - Return raises pointer by two, restores counter; skip variant skips next.
// - Interrupt return restores counter like return and sets global interrupt enable.
// - Software trap stacks counter like a call and jumps to 0FF.
// - A skipped instruction is processed as a no-operation with no effects.
// - Skipping takes as many cycles as the skipped instruction has bytes.
`timescale 1ns/1ps
module cpu_exec_core
   import cpu_exec_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic ce_in,
   input wire logic instr_valid_in,
   input wire instr_t instr_in,
   output logic instr_ready_out,
   output logic [PC_W-1:0] pc_out,
   output logic boot_fetch_out,
   output logic [7:0] dmem_addr_out,
   output logic [7:0] dmem_wdata_out,
   output logic dmem_we_out,
   input wire logic [7:0] dmem_rdata_in,
   output logic [PC_W-1:0] pmem_addr_out,
   input wire logic [7:0] pmem_rdata_in,
   output core_state_t state_out
);

   typedef enum logic [3:0] {
      st_idle, st_mem_rd, st_ret_lo, st_ret_hi, st_call_hi, st_pm_rd, st_vec_hi, st_vec_lo, st_skip
   } seq_t;

   seq_t seq_q;
   instr_t ins_q;
   logic [PC_W-1:0] pc_q;
   logic [7:0] a_q, b_q, x_q, sp_q;
   logic c_q, hc_q, gie_q, skip_q, boot_q;
   logic [1:0] skip_cnt_q;
   logic [7:0] addr_q, wdata_q;
   logic we_q;
   logic [PC_W-1:0] paddr_q;

   // ----------------------------------------------------------------
   // Operand selection and arithmetic
   // ----------------------------------------------------------------
   instr_t cur;
   logic accept, exec_now, needs_mem;
   logic [7:0] opnd, ea, a_d, wr_data;
   logic c_d, hc_d, do_next, wr_en;
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic [7:0] dec8;
   logic [PC_W-1:0] pc_seq;

   assign instr_ready_out = (seq_q == st_idle);
   assign accept = ce_in && instr_ready_out && instr_valid_in;
   assign cur = (seq_q == st_idle) ? instr_in : ins_q;
   assign pc_seq = pc_q + PC_W'(instr_in.len);

   always_comb begin
      case (cur.op)
         op_add, op_adc, op_subtract_with_carry, op_and, op_or, op_xor,
         op_test_equal, op_test_not_equal, op_test_greater, op_load_a:
            needs_mem = !cur.src_imm;
         op_test_equal_direct, op_decrement_skip_zero, op_bit_set, op_bit_clear, op_exchange_a, op_pop:
            needs_mem = 1'b1;
         default:
            needs_mem = 1'b0;
      endcase
   end

   always_comb begin
      if (cur.op == op_decrement_skip_zero) begin
         ea = REG_PAGE | {4'h0, cur.direct_memory_operand[3:0]};
      end else if (cur.mode == mode_first_ptr) begin
         ea = b_q;
      end else if (cur.mode == mode_second_ptr) begin
         ea = x_q;
      end else begin
         ea = cur.direct_memory_operand;
      end
   end

   // Immediate forms execute on acceptance; memory forms one cycle later with the read data.
   assign opnd = (seq_q == st_idle) ? cur.imm : dmem_rdata_in;
   assign exec_now = (accept && !skip_q && !needs_mem) || (ce_in && seq_q == st_mem_rd);
   assign dec8 = opnd - 8'h01;

   always_comb begin
      a_d = a_q;
      c_d = c_q;
      hc_d = hc_q;
      do_next = 1'b1;
      wr_en = 1'b0;
      wr_data = opnd;
      sum9 = 9'h000;
      sum5 = 5'h00;
      case (cur.op)
         op_add: begin
            a_d = a_q + opnd;
         end
         op_adc: begin
            sum9 = {1'b0, a_q} + {1'b0, opnd} + {8'h00, c_q};
            sum5 = {1'b0, a_q[3:0]} + {1'b0, opnd[3:0]} + {4'h0, c_q};
            a_d = sum9[7:0];
            c_d = sum9[8];
            hc_d = sum5[4];
         end
         op_subtract_with_carry: begin
            // Carry acts as not-borrow, so the subtract is an add of the complement.
            sum9 = {1'b0, a_q} + {1'b0, ~opnd} + {8'h00, c_q};
            sum5 = {1'b0, a_q[3:0]} + {1'b0, ~opnd[3:0]} + {4'h0, c_q};
            a_d = sum9[7:0];
            c_d = sum9[8];
            hc_d = sum5[4];
         end
         op_and: a_d = a_q & opnd;
         op_or: a_d = a_q | opnd;
         op_xor: a_d = a_q ^ opnd;
         op_and_immediate_skip: do_next = ((a_q & opnd) != 8'h00);
         op_test_equal_direct: do_next = (opnd == cur.imm);
         op_test_equal: do_next = (a_q == opnd);
         op_test_not_equal: do_next = (a_q != opnd);
         op_test_greater: do_next = (a_q > opnd);
         op_pointer_nibble_test: do_next = (b_q[3:0] != cur.imm[3:0]);
         op_decrement_skip_zero: begin
            wr_en = 1'b1;
            wr_data = dec8;
            do_next = (dec8 != 8'h00);
         end
         op_bit_set: begin
            wr_en = 1'b1;
            wr_data = opnd | (8'h01 << cur.bit_num);
         end
         op_bit_clear: begin
            wr_en = 1'b1;
            wr_data = opnd & ~(8'h01 << cur.bit_num);
         end
         op_load_a, op_pop: a_d = opnd;
         op_exchange_a: begin
            a_d = opnd;
            wr_en = 1'b1;
            wr_data = a_q;
         end
         op_rotate_right_carry: begin
            a_d = {c_q, a_q[7:1]};
            c_d = a_q[0];
         end
         op_rotate_left_carry: begin
            a_d = {a_q[6:0], c_q};
            c_d = a_q[7];
            hc_d = a_q[0];
         end
         default: begin
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencer, skip handling and program counter
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         seq_q <= st_idle;
         ins_q <= '0;
         pc_q <= PC_RESET;
         skip_q <= 1'b0;
         skip_cnt_q <= 2'h0;
         boot_q <= 1'b0;
         gie_q <= 1'b0;
      end else if (ce_in) begin
         case (seq_q)
            st_idle: begin
               if (instr_valid_in) begin
                  ins_q <= instr_in;
                  pc_q <= pc_seq;
                  if (skip_q) begin
                     // The skipped instruction still occupies one cycle per byte, with no effect.
                     skip_q <= 1'b0;
                     if (instr_in.len > SKIP_ONE) begin
                        skip_cnt_q <= instr_in.len - SKIP_ONE;
                        seq_q <= st_skip;
                     end
                  end else if (needs_mem) begin
                     seq_q <= st_mem_rd;
                  end else begin
                     skip_q <= !do_next;
                     case (instr_in.op)
                        op_table_read, op_vector_dispatch: seq_q <= st_pm_rd;
                        op_long_jump: pc_q <= instr_in.target;
                        op_absolute_jump: pc_q[ABS_W-1:0] <= instr_in.target[ABS_W-1:0];
                        op_relative_jump: pc_q <= pc_q + PC_W'(instr_in.disp);
                        op_long_call, op_short_call, op_boot_call, op_software_trap: seq_q <= st_call_hi;
                        op_subroutine_return, op_return_and_skip, op_interrupt_return: seq_q <= st_ret_lo;
                        default: begin
                        end
                     endcase
                  end
               end
            end
            st_skip: begin
               skip_cnt_q <= skip_cnt_q - SKIP_ONE;
               if (skip_cnt_q == SKIP_ONE) begin
                  seq_q <= st_idle;
               end
            end
            st_mem_rd: begin
               skip_q <= !do_next;
               seq_q <= st_idle;
            end
            st_pm_rd: begin
               if (ins_q.op == op_vector_dispatch) begin
                  pc_q[PC_W-1:8] <= pmem_rdata_in[6:0];
                  seq_q <= st_vec_lo;
               end else begin
                  seq_q <= st_idle;
               end
            end
            st_vec_lo: begin
               pc_q[7:0] <= pmem_rdata_in;
               seq_q <= st_idle;
            end
            st_call_hi: begin
               seq_q <= st_idle;
               case (ins_q.op)
                  op_long_call: pc_q <= ins_q.target;
                  op_short_call: pc_q[ABS_W-1:0] <= ins_q.target[ABS_W-1:0];
                  op_boot_call: begin
                     pc_q <= {BOOT_HIGH, ins_q.target[7:0]};
                     boot_q <= 1'b1;
                  end
                  default: pc_q <= TRAP_ADDR;
               endcase
            end
            st_ret_lo: begin
               pc_q[7:0] <= dmem_rdata_in;
               seq_q <= st_ret_hi;
            end
            st_ret_hi: begin
               pc_q[PC_W-1:8] <= dmem_rdata_in[6:0];
               boot_q <= 1'b0;
               skip_q <= (ins_q.op == op_return_and_skip);
               if (ins_q.op == op_interrupt_return) begin
                  gie_q <= 1'b1;
               end
               seq_q <= st_idle;
            end
            default: seq_q <= st_idle;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Accumulator and flags
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         a_q <= 8'h00;
         c_q <= 1'b0;
         hc_q <= 1'b0;
      end else if (ce_in) begin
         if (exec_now) begin
            a_q <= a_d;
            c_q <= c_d;
            hc_q <= hc_d;
         end else if (seq_q == st_pm_rd && ins_q.op == op_table_read) begin
            a_q <= pmem_rdata_in;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pointers and stack pointer
   // ----------------------------------------------------------------
   logic [7:0] step;
   assign step = (instr_in.adj == adj_inc) ? 8'h01 : (instr_in.adj == adj_dec) ? 8'hFF : 8'h00;
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         b_q <= PTR_RESET;
         x_q <= PTR_RESET;
         sp_q <= SP_RESET;
      end else if (ce_in) begin
         if (accept && !skip_q) begin
            case (instr_in.op)
               op_load_first_ptr: b_q <= instr_in.imm;
               op_load_second_ptr: x_q <= instr_in.imm;
               op_push: sp_q <= sp_q - 8'h01;
               op_pop: sp_q <= sp_q + 8'h01;
               default: begin
               end
            endcase
            if ((instr_in.op == op_load_a || instr_in.op == op_exchange_a) && !instr_in.src_imm) begin
               if (instr_in.mode == mode_first_ptr) b_q <= b_q + step;
               if (instr_in.mode == mode_second_ptr) x_q <= x_q + step;
            end
         end else if (seq_q == st_call_hi) begin
            sp_q <= sp_q - 8'h02;
         end else if (seq_q == st_ret_hi) begin
            sp_q <= sp_q + 8'h02;
         end
      end
   end

   // ----------------------------------------------------------------
   // Memory ports
   // ----------------------------------------------------------------
   // Pop shares the read cycle with ordinary memory operands, so its load rides on the same path.
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         addr_q <= 8'h00;
         wdata_q <= 8'h00;
         we_q <= 1'b0;
         paddr_q <= PC_RESET;
      end else if (ce_in) begin
         we_q <= 1'b0;
         if (accept && !skip_q) begin
            case (instr_in.op)
               op_push: begin
                  addr_q <= sp_q;
                  wdata_q <= a_q;
                  we_q <= 1'b1;
               end
               op_pop: addr_q <= sp_q + 8'h01;
               op_long_call, op_short_call, op_boot_call, op_software_trap: begin
                  addr_q <= sp_q;
                  wdata_q <= pc_seq[7:0];
                  we_q <= 1'b1;
               end
               op_subroutine_return, op_return_and_skip, op_interrupt_return: addr_q <= sp_q + 8'h02;
               op_table_read: paddr_q <= {pc_q[PC_W-1:8], a_q};
               op_vector_dispatch: paddr_q <= instr_in.target;
               default: addr_q <= ea;
            endcase
         end else if (seq_q == st_call_hi) begin
            addr_q <= sp_q - 8'h01;
            wdata_q <= {1'b0, pc_q[PC_W-1:8]};
            we_q <= 1'b1;
         end else if (seq_q == st_ret_lo) begin
            addr_q <= sp_q + 8'h01;
         end else if (seq_q == st_pm_rd) begin
            paddr_q <= paddr_q + 15'h0001;
         end else if (seq_q == st_mem_rd && wr_en) begin
            wdata_q <= wr_data;
            we_q <= 1'b1;
         end
      end
   end

   assign pc_out = pc_q;
   assign boot_fetch_out = boot_q;
   assign dmem_addr_out = addr_q;
   assign dmem_wdata_out = wdata_q;
   assign dmem_we_out = we_q;
   assign pmem_addr_out = paddr_q;
   assign state_out = '{accum: a_q, first_ptr: b_q, second_ptr: x_q, stack_pointer: sp_q, carry: c_q,
                        half_carry: hc_q, global_irq_enable: gie_q, skip_pending: skip_q};

endmodule // cpu_exec_core

// ### cpu_exec_mem.sv
// Behavioural data and program memory facing the execution core.
`timescale 1ns/1ps
module cpu_exec_mem (
   input wire logic sys_clk_in,
   input wire logic [7:0] dmem_addr_in,
   input wire logic [7:0] dmem_wdata_in,
   input wire logic dmem_we_in,
   output logic [7:0] dmem_rdata_out,
   input wire logic [14:0] pmem_addr_in,
   output logic [7:0] pmem_rdata_out
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0] mem [256];
   // Every byte differs from its neighbours so a wrong address shows up.
   assign dmem_rdata_out = mem[dmem_addr_in];
   assign pmem_rdata_out = pmem_addr_in[7:0] ^ {1'b0, pmem_addr_in[14:8]} ^ 8'h5A;
   initial begin
      for (int k = 0; k < 256; k++) begin
         mem[k] = 8'(k) ^ 8'hA5;
      end
   end
   always @(posedge sys_clk_in) begin
      if (dmem_we_in) begin
         mem[dmem_addr_in] <= dmem_wdata_in;
      end
   end
   task automatic poke(input logic [7:0] a, input logic [7:0] v);
      mem[a] = v;
   endtask
endmodule // cpu_exec_mem

// ### cpu_exec_pkg.sv
// Package for the instruction execution core: opcodes, instruction carrier, state view, constants.
package cpu_exec_pkg;

   // ----------------------------------------------------------------
   // Widths and fixed values
   // ----------------------------------------------------------------
   localparam int PC_W = 15;
   localparam int ABS_W = 12;
   localparam logic [7:0] REG_PAGE = 8'hF0;
   localparam logic [PC_W-1:0] TRAP_ADDR = 15'h00FF;
   localparam logic [6:0] BOOT_HIGH = 7'h00;
   localparam logic [7:0] SP_RESET = 8'hEF;
   localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [1:0] SKIP_ONE = 2'h1;

   // ----------------------------------------------------------------
   // Operations understood by the core
   // ----------------------------------------------------------------
   typedef enum logic [5:0] {
      op_nop, op_add, op_adc, op_subtract_with_carry, op_and, op_or, op_xor,
      op_and_immediate_skip, op_test_equal_direct, op_test_equal, op_test_not_equal,
      op_test_greater, op_pointer_nibble_test, op_decrement_skip_zero, op_bit_set,
      op_bit_clear, op_load_a, op_exchange_a, op_load_first_ptr, op_load_second_ptr,
      op_table_read, op_rotate_right_carry, op_rotate_left_carry, op_push, op_pop,
      op_vector_dispatch, op_long_jump, op_absolute_jump, op_relative_jump,
      op_long_call, op_short_call, op_boot_call, op_subroutine_return,
      op_return_and_skip, op_interrupt_return, op_software_trap
   } op_t;

   typedef enum logic [1:0] {mode_direct, mode_first_ptr, mode_second_ptr} mode_t;
   typedef enum logic [1:0] {adj_none, adj_inc, adj_dec} adj_t;

   // ----------------------------------------------------------------
   // Decoded instruction and visible core state
   // ----------------------------------------------------------------
   typedef struct packed {
      op_t op;
      logic src_imm;
      mode_t mode;
      adj_t adj;
      logic [7:0] imm;
      logic [7:0] direct_memory_operand;
      logic [2:0] bit_num;
      logic [PC_W-1:0] target;
      logic signed [6:0] disp;
      logic [1:0] len;
   } instr_t;

   typedef struct packed {
      logic [7:0] accum;
      logic [7:0] first_ptr;
      logic [7:0] second_ptr;
      logic [7:0] stack_pointer;
      logic carry;
      logic half_carry;
      logic global_irq_enable;
      logic skip_pending;
   } core_state_t;

endpackage

// ### cpu_exec_props.sv
// Checker of the execution core's port behaviour.
`timescale 1ns/1ps
module cpu_exec_props
   import cpu_exec_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic ce_in,
   input wire logic instr_valid_in,
   input wire instr_t instr_in,
   input wire logic instr_ready_out,
   input wire logic [PC_W-1:0] pc_out,
   input wire logic boot_fetch_out,
   input wire logic [7:0] dmem_addr_out,
   input wire logic [7:0] dmem_wdata_out,
   input wire logic dmem_we_out,
   input wire logic [7:0] dmem_rdata_in,
   input wire logic [PC_W-1:0] pmem_addr_out,
   input wire logic [7:0] pmem_rdata_in,
   input wire core_state_t state_out
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   logic tk, tks;
   assign tk = ce_in && instr_valid_in && instr_ready_out && !state_out.skip_pending;
   assign tks = ce_in && instr_valid_in && instr_ready_out && state_out.skip_pending;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);
   reset_values_a: assert property ($fell(srst_in) |-> pc_out == PC_RESET && state_out.stack_pointer == SP_RESET)
      else $error("Reset values wrong.");
   push_order_a: assert property (
      tk && instr_in.op == op_push |=> dmem_we_out && dmem_addr_out == $past(state_out.stack_pointer)
      && dmem_wdata_out == $past(state_out.accum) && state_out.stack_pointer == $past(state_out.stack_pointer) - 8'h01)
      else $error("Push wrong.");
   and_skip_a: assert property (
      tk && instr_in.op == op_and_immediate_skip |=> state_out.accum == $past(state_out.accum)
      && state_out.skip_pending == (($past(state_out.accum) & $past(instr_in.imm)) == 8'h00))
      else $error("And-skip wrong.");
   long_jump_a: assert property (tk && instr_in.op == op_long_jump |=> pc_out == $past(instr_in.target))
      else $error("Long jump target wrong.");
   abs_jump_a: assert property (
      tk && instr_in.op == op_absolute_jump |=> pc_out == {$past(pc_out[14:12]), $past(instr_in.target[11:0])})
      else $error("Absolute jump target wrong.");
   rel_jump_a: assert property (
      tk && instr_in.op == op_relative_jump |=> pc_out == $past(pc_out) + PC_W'($past(instr_in.disp)))
      else $error("Relative jump target wrong.");
   trap_vector_a: assert property (tk && instr_in.op == op_software_trap |-> ##[1:4] pc_out == TRAP_ADDR)
      else $error("Trap missed.");
   skip_noop_a: assert property (
      tks |=> !dmem_we_out && state_out.accum == $past(state_out.accum) && state_out.carry == $past(state_out.carry)
      && state_out.stack_pointer == $past(state_out.stack_pointer))
      else $error("Skip had effect.");
   skip_time_a: assert property (tks && instr_in.len == 2'h2 |=> !instr_ready_out ##1 instr_ready_out)
      else $error("Skip time wrong.");
   irq_return_a: assert property (tk && instr_in.op == op_interrupt_return |-> ##[1:4] state_out.global_irq_enable)
      else $error("Interrupt enable not set.");
   boot_call_a: assert property (
      tk && instr_in.op == op_boot_call |-> ##[1:4] boot_fetch_out && pc_out[14:8] == BOOT_HIGH)
      else $error("Boot call wrong.");
endmodule // cpu_exec_props

// ### tb_cpu_exec_core.sv
// Self-checking testbench of the instruction execution core.
`timescale 1ns/1ps
module tb_cpu_exec_core
   import cpu_exec_pkg::*;
;
   // ----------------------------------------------------------------
   // Harness
   // ----------------------------------------------------------------
   logic sys_clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic ce_in = 1'b1;
   logic instr_valid_in = 1'b0;
   instr_t instr_in = '0;
   logic instr_ready_out, boot_fetch_out, dmem_we_out, rdy_n;
   logic [7:0] dmem_addr_out, dmem_wdata_out, dmem_rdata_in, pmem_rdata_in;
   logic [PC_W-1:0] pc_out, pmem_addr_out;
   core_state_t st;
   int bad_count = 0;
   int checked = 0;
   always #20 sys_clk_in = ~sys_clk_in;
   // Ready is sampled mid-cycle so the taking edge never races the driver.
   always @(negedge sys_clk_in) rdy_n <= instr_ready_out;
   cpu_exec_core cpu_exec_core_i (.*, .state_out(st));
   cpu_exec_mem cpu_exec_mem_i (.sys_clk_in(sys_clk_in), .dmem_addr_in(dmem_addr_out), .dmem_wdata_in(dmem_wdata_out),
      .dmem_we_in(dmem_we_out), .dmem_rdata_out(dmem_rdata_in), .pmem_addr_in(pmem_addr_out),
      .pmem_rdata_out(pmem_rdata_in));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
      end
   endtask
   function automatic instr_t mk(input op_t op, input logic [7:0] imm, input logic [1:0] len);
      instr_t i;
      i = '0;
      i.op = op;
      i.src_imm = 1'b1;
      i.imm = imm;
      i.len = len;
      return i;
   endfunction
   task automatic run(input instr_t i);
      int n;
      n = 0;
      @(posedge sys_clk_in);
      instr_in <= i;
      instr_valid_in <= 1'b1;
      do @(posedge sys_clk_in); while (!rdy_n && ++n < 20);
      instr_valid_in <= 1'b0;
      do @(posedge sys_clk_in); while (!rdy_n && ++n < 40);
      if (n >= 40) chk(0, 1, "no answer");
      @(negedge sys_clk_in);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_arith();
      run(mk(op_load_a, 8'h3C, 2));
      run(mk(op_adc, 8'h0F, 2));
      chk({st.accum, st.carry, st.half_carry}, {8'h4B, 2'b01}, "add with carry");
      run(mk(op_subtract_with_carry, 8'h0B, 2));
      chk({st.accum, st.carry, st.half_carry}, {8'h3F, 2'b10}, "subtract with carry");
      run(mk(op_rotate_right_carry, 8'h00, 1));
      chk({st.accum, st.carry}, {8'h9F, 1'b1}, "rotate right");
      run(mk(op_rotate_left_carry, 8'h00, 1));
      chk({st.accum, st.carry, st.half_carry}, {8'h3F, 2'b11}, "rotate left");
      $display("Test arith done");
   endtask
   task automatic t_skip();
      op_t ops [10] = '{op_test_equal, op_test_not_equal, op_test_greater, op_test_greater, op_and_immediate_skip,
         op_and_immediate_skip, op_test_equal_direct, op_test_equal_direct, op_pointer_nibble_test,
         op_pointer_nibble_test};
      logic [7:0] ims [10] = '{8'h3F, 8'h3F, 8'h3E, 8'h3F, 8'hC0, 8'h01, 8'h77, 8'h78, 8'h05, 8'h06};
      logic sks [10] = '{0, 1, 0, 1, 1, 0, 0, 1, 1, 0};
      instr_t i;
      cpu_exec_mem_i.poke(8'h20, 8'h77);
      run(mk(op_load_first_ptr, 8'h35, 2));
      for (int k = 0; k < 10; k++) begin
         i = mk(ops[k], ims[k], 2);
         i.direct_memory_operand = 8'h20;
         run(i);
         chk({st.accum, st.skip_pending}, {8'h3F, sks[k]}, "condition");
         run(mk(op_load_a, sks[k] ? 8'h55 : 8'h3F, 2));
         chk({st.accum, st.skip_pending}, {8'h3F, 1'b0}, "skipped load");
      end
      $display("Test skip done");
   endtask
   task automatic t_mem();
      instr_t i;
      cpu_exec_mem_i.poke(8'hF5, 8'h02);
      i = mk(op_decrement_skip_zero, 8'h00, 1);
      i.direct_memory_operand = 8'hF5;
      run(i);
      chk({cpu_exec_mem_i.mem[8'hF5], st.skip_pending}, {8'h01, 1'b0}, "decrement");
      run(i);
      chk({cpu_exec_mem_i.mem[8'hF5], st.skip_pending}, {8'h00, 1'b1}, "decrement to zero");
      run(mk(op_nop, 8'h00, 1));
      i = mk(op_bit_set, 8'h00, 3);
      i.direct_memory_operand = 8'h20;
      i.bit_num = 3'h7;
      run(i);
      chk(cpu_exec_mem_i.mem[8'h20], 8'hF7, "bit set");
      i.op = op_bit_clear;
      i.bit_num = 3'h0;
      run(i);
      chk(cpu_exec_mem_i.mem[8'h20], 8'hF6, "bit clear");
      cpu_exec_mem_i.poke(8'h35, 8'hA5);
      i = mk(op_load_a, 8'h00, 1);
      i.src_imm = 1'b0;
      i.mode = mode_first_ptr;
      i.adj = adj_inc;
      run(i);
      chk({st.accum, st.first_ptr}, 16'hA536, "load post increment");
      i.op = op_exchange_a;
      i.adj = adj_dec;
      run(i);
      chk({st.accum, st.first_ptr, cpu_exec_mem_i.mem[8'h36]}, 24'h9335A5, "exchange post decrement");
      run(mk(op_push, 8'h00, 1));
      chk({cpu_exec_mem_i.mem[8'hEF], st.stack_pointer}, 16'h93EE, "push");
      run(mk(op_load_a, 8'h00, 2));
      run(mk(op_pop, 8'h00, 1));
      chk({st.accum, st.stack_pointer}, 16'h93EF, "pop");
      $display("Test memory done");
   endtask
   task automatic t_flow();
      op_t cop [4] = '{op_long_call, op_software_trap, op_boot_call, op_long_call};
      op_t rop [4] = '{op_subroutine_return, op_interrupt_return, op_subroutine_return, op_return_and_skip};
      logic [1:0] cl [4] = '{2'h3, 2'h1, 2'h2, 2'h3};
      logic [14:0] dst [4] = '{15'h1234, 15'h00FF, 15'h0040, 15'h1234};
      instr_t i;
      logic [14:0] p;
      i = mk(op_long_jump, 8'h00, 3);
      i.target = 15'h7ABC;
      run(i);
      chk(pc_out, 15'h7ABC, "long jump");
      i.op = op_absolute_jump;
      i.target = 15'h0125;
      run(i);
      chk(pc_out, 15'h7125, "absolute jump");
      i = mk(op_relative_jump, 8'h00, 1);
      i.disp = -7'sd31;
      run(i);
      chk(pc_out, 15'h7106, "jump back");
      i.disp = 7'sd32;
      run(i);
      chk(pc_out, 15'h7126, "jump ahead");
      run(mk(op_load_a, 8'h1F, 2));
      run(mk(op_table_read, 8'h00, 1));
      chk(st.accum, 8'h1F ^ 8'h71 ^ 8'h5A, "table read");
      i = mk(op_vector_dispatch, 8'h00, 1);
      i.target = 15'h0300;
      run(i);
      chk(pc_out, 15'h5958, "vector");
      chk(st.global_irq_enable, 1'b0, "irq enable idle");
      for (int k = 0; k < 4; k++) begin
         p = pc_out + 15'(cl[k]);
         i = mk(cop[k], 8'h40, cl[k]);
         i.target = dst[k];
         run(i);
         chk({pc_out, boot_fetch_out, st.stack_pointer}, {dst[k], k == 2, 8'hED}, "call");
         chk({cpu_exec_mem_i.mem[8'hEE], cpu_exec_mem_i.mem[8'hEF]}, {1'b0, p}, "stacked return");
         run(mk(rop[k], 8'h00, 1));
         chk({pc_out, st.stack_pointer, boot_fetch_out, st.skip_pending}, {p, 8'hEF, 1'b0, k == 3}, "return");
      end
      chk(st.global_irq_enable, 1'b1, "irq enable");
      run(mk(op_nop, 8'h00, 1));
      $display("Test flow done");
   endtask
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge sys_clk_in);
      srst_in <= 1'b0;
      @(negedge sys_clk_in);
      chk({pc_out, st.stack_pointer}, {PC_RESET, SP_RESET}, "reset");
      t_arith();
      t_skip();
      t_mem();
      t_flow();
      finish_test();
   end
   // Tests need a few hundred cycles; this allows 2500.
   initial begin
      #100000;
      bad_count++;
      finish_test();
   end
endmodule // tb_cpu_exec_core
bind cpu_exec_core cpu_exec_props cpu_exec_props_i (.*);
